// ===== rtl/cmw_pkg.sv
// package of the clock, mode and wake-up controller
// assumes one system clock and an avalon-mm register slave
package cmw_pkg;

	// ----------------------------------------------------------
	// register map, byte addresses
	// ----------------------------------------------------------
	localparam logic [4:0] OFS_OSC_CTRL  = 5'h00;
	localparam logic [4:0] OFS_IRQ_FLAG  = 5'h04;
	localparam logic [4:0] OFS_IRQ_EN    = 5'h08;
	localparam logic [4:0] OFS_PORT_CFG  = 5'h0c;
	localparam logic [4:0] OFS_STATUS    = 5'h10;

	// ----------------------------------------------------------
	// field positions
	// ----------------------------------------------------------
	localparam int OSC_SEL_BIT   = 0;
	localparam int OSC_STOP_BIT  = 1;
	localparam int OSC_MODE_LSB  = 2;
	localparam int IRQ_T0_BIT    = 0;
	localparam int IRQ_T1_BIT    = 1;
	localparam int IRQ_WDT_BIT   = 2;
	localparam int IRQ_PORT_BIT  = 3;
	localparam int IRQ_EXT_BIT   = 4;
	localparam int IRQ_LVD_BIT   = 5;
	localparam int IRQ_W         = 6;
	localparam int PORT_W        = 6;
	localparam int PCFG_EXT_SEL  = 8;
	localparam int PCFG_EDGE_SEL = 9;
	localparam int ST_GIE_BIT    = 0;
	localparam int ST_PD_BIT     = 3;
	localparam int ST_TO_BIT     = 4;
	localparam int ST_MODE_LSB   = 8;

	// ----------------------------------------------------------
	// codes, reset values and timing
	// ----------------------------------------------------------
	localparam logic [1:0] MODE_STANDBY = 2'b10;
	localparam logic [1:0] MODE_HALT    = 2'b01;
	localparam logic [1:0] MODE_NONE    = 2'b00;
	localparam logic [10:0] IRQ_VECTOR  = 11'h008;
	localparam int WAKE_HALT_CYCLES     = 16;
	localparam logic [4:0] WAKE_LAST    = 5'(WAKE_HALT_CYCLES - 1);
	localparam int LOW_OSC_HZ           = 32768;
	localparam logic [15:0] LOW_OSC_HZ_W = 16'(LOW_OSC_HZ);

	// high rc frequency in khz per configuration code 0..5
	function automatic logic [15:0] hrc_khz(input logic [2:0] code);
		case (code)
			3'h0: hrc_khz = 16'h03e8;
			3'h1: hrc_khz = 16'h07d0;
			3'h2: hrc_khz = 16'h0fa0;
			3'h3: hrc_khz = 16'h1f40;
			3'h4: hrc_khz = 16'h3e80;
			3'h5: hrc_khz = 16'h4e20;
			default: hrc_khz = 16'h0000;
		endcase
	endfunction

	// operating state, one-hot
	typedef enum logic [4:0] {
		ST_BOOT    = 5'b00001,
		ST_RUN     = 5'b00010,
		ST_STANDBY = 5'b00100,
		ST_HALT    = 5'b01000,
		ST_WAKE    = 5'b10000
	} cmw_state_e;

	// configuration words from the fuse block
	typedef struct packed {
		logic       wdt_irq_mode;
		logic       inst_div4;
		logic       startup_high;
		logic [2:0] hrc_code;
	} cmw_cfg_s;

	// clock and gating outputs toward the rest of the chip
	typedef struct packed {
		logic        high_osc_en;
		logic        low_osc_en;
		logic        sys_clock_select;
		logic        exec_run;
		logic        periph_run;
		logic        timer_run;
		logic [15:0] high_osc_khz;
		logic [15:0] low_osc_hz;
	} cmw_clk_s;

endpackage

// ===== rtl/cmw_ctrl.sv
// clock selection, operating mode and wake-up / interrupt controller
// assumes i_clk is the system clock, core strobes are on i_clk,
// pins, lvd and watchdog timeout come from other domains
//
// Behaviour
// - watchdog timeout in interrupt mode sets its flag; served with enables
// - level change on selected input pins 0..5 sets the port flag
// - pin 0 change detection is masked while external select is on
// - chosen edge of pin 0 sets the external flag when selected
// - low-voltage indication falling sets the low-voltage flag
// - clock select bit 0 picks high oscillator at 1, low at 0
// - writing 1 to bit 1 stops the high oscillator
// - halt turns off both oscillators, execution and all peripherals
// - high rc frequency from configuration code; low rc is 32768 Hz
// - instruction clock is system clock divided by 2 or 4
// - after reset start normal or slow per startup configuration
// - clock select 0 gives slow, 1 gives normal; low osc stays on
// - mode field bits 3:2: 10 enters standby, 01 enters halt
// - sleep also halts; clears power-down, sets timeout, clears wdt
// - standby stops execution; timers and low oscillator keep running
// - standby ends on any of the six hardware events
// - halt ends only on watchdog, port change or external event
// - after wake, normal or slow follows the clock select bit
// - wake from halt waits 16 system clocks; standby waits none
// - wake with global enable vectors to 0x008, else continues
// - interrupt flags stay set until firmware writes 0
// - taken interrupt vectors to 0x008 and clears global enable
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ns

module cmw_ctrl
	import cmw_pkg::*;
(
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	// avalon-mm slave
	input  wire logic [4:0]         i_address,
	input  wire logic               i_read,
	input  wire logic               i_write,
	input  wire logic [3:0]         i_byteenable,
	input  wire logic [31:0]        i_writedata,
	output logic      [31:0]        o_readdata,
	output logic                    o_waitrequest,
	// configuration words
	input  wire cmw_cfg_s           i_cfg,
	// core strobes, one cycle each
	input  wire logic               i_sleep_instr,
	input  wire logic               i_irq_enable_instr,
	input  wire logic               i_irq_disable_instr,
	input  wire logic               i_timer0_ovf,
	input  wire logic               i_timer1_udf,
	// asynchronous event sources
	input  wire logic [PORT_W-1:0]  i_port_pins,
	input  wire logic [PORT_W-1:0]  i_port_is_input,
	input  wire logic               i_low_volt_ok,
	input  wire logic               i_wdt_timeout,
	// outputs
	output cmw_clk_s                o_clk,
	output logic                    o_instruction_clock,
	output logic                    o_irq_pending,
	output logic                    o_vector_take,
	output logic      [10:0]        o_vector_addr,
	output logic                    o_wdt_clear,
	output logic                    o_power_down_status_n,
	output logic                    o_timeout_status_n
);

	// ----------------------------------------------------------
	// state
	// ----------------------------------------------------------
	typedef struct packed {
		cmw_state_e          st;
		logic                sys_clock_select;
		logic                high_osc_stop;
		logic [1:0]          low_power_mode_field;
		logic [IRQ_W-1:0]    flag;
		logic [IRQ_W-1:0]    enable;
		logic [PORT_W-1:0]   port_wake_select;
		logic                ext_irq_select;
		logic                ext_edge_select;
		logic                global_irq_enable;
		logic                power_down_status_n;
		logic                timeout_status_n;
		logic [4:0]          wake_cnt;
		logic [1:0]          div_cnt;
		logic                inst_pulse;
		logic                vec_pulse;
		logic                wdt_clr;
		logic                ack;
		logic [31:0]         rdata;
		logic [15:0]         hosc_khz;
		logic [PORT_W-1:0]   pin_m;
		logic [PORT_W-1:0]   pin_s;
		logic [PORT_W-1:0]   pin_p;
		logic                lvd_m;
		logic                lvd_s;
		logic                lvd_p;
		logic                wdt_m;
		logic                wdt_s;
		logic                wdt_p;
	} cmw_reg_s;

	cmw_reg_s s_r;
	cmw_reg_s s_nxt;

	// ----------------------------------------------------------
	// helpers
	// ----------------------------------------------------------
	// a write hits a register when the address matches and the byte lane passed in is on
	function automatic logic wr_hit(input logic [4:0] a,
	                                input logic [4:0] ofs,
	                                input logic       en);
		wr_hit = en && (a == ofs);
	endfunction

	// ----------------------------------------------------------
	// event detection on synchronised inputs
	// ----------------------------------------------------------
	logic [PORT_W-1:0] chg_mask;
	logic [PORT_W-1:0] pin_chg;
	logic              ev_wdt;
	logic              ev_port;
	logic              ev_ext;
	logic              ev_lvd;
	logic [IRQ_W-1:0]  ev_all;
	logic              halt_wake;
	logic              stby_wake;
	logic              bus_req;
	logic              do_wr;
	logic              do_rd;

	// pin 0 leaves change detection to the external edge logic while external select is on
	always_comb begin
		chg_mask    = s_r.port_wake_select & i_port_is_input;
		chg_mask[0] = chg_mask[0] & ~s_r.ext_irq_select;
	end

	// only second and third stages are compared, never the first
	assign pin_chg = (s_r.pin_s ^ s_r.pin_p) & chg_mask;
	assign ev_port = |pin_chg;
	assign ev_ext  = s_r.ext_irq_select & (s_r.ext_edge_select ?
	                 (s_r.pin_s[0] & ~s_r.pin_p[0]) :
	                 (~s_r.pin_s[0] & s_r.pin_p[0]));
	assign ev_lvd  = ~s_r.lvd_s & s_r.lvd_p;
	// one rising edge of the timeout level gives one event
	assign ev_wdt  = s_r.wdt_s & ~s_r.wdt_p & i_cfg.wdt_irq_mode;

	always_comb begin
		ev_all               = '0;
		ev_all[IRQ_T0_BIT]   = i_timer0_ovf;
		ev_all[IRQ_T1_BIT]   = i_timer1_udf;
		ev_all[IRQ_WDT_BIT]  = ev_wdt;
		ev_all[IRQ_PORT_BIT] = ev_port;
		ev_all[IRQ_EXT_BIT]  = ev_ext;
		ev_all[IRQ_LVD_BIT]  = ev_lvd;
	end

	// wake sources differ per mode
	assign stby_wake = |ev_all;
	assign halt_wake = ev_wdt | ev_port | ev_ext;

	// ----------------------------------------------------------
	// avalon handshake: one wait cycle, then the access completes
	// ----------------------------------------------------------
	assign bus_req       = i_read | i_write;
	assign o_waitrequest = bus_req & ~s_r.ack;
	assign do_wr         = i_write & s_r.ack;
	assign do_rd         = i_read & ~s_r.ack;

	// ----------------------------------------------------------
	// next state
	// ----------------------------------------------------------
	always_comb begin
		s_nxt            = s_r;
		s_nxt.vec_pulse  = 1'b0;
		s_nxt.wdt_clr    = 1'b0;
		s_nxt.inst_pulse = 1'b0;
		s_nxt.ack        = bus_req & ~s_r.ack;

		// synchronisers
		s_nxt.pin_m = i_port_pins;
		s_nxt.pin_s = s_r.pin_m;
		s_nxt.pin_p = s_r.pin_s;
		s_nxt.lvd_m = i_low_volt_ok;
		s_nxt.lvd_s = s_r.lvd_m;
		s_nxt.lvd_p = s_r.lvd_s;
		s_nxt.wdt_m = i_wdt_timeout;
		s_nxt.wdt_s = s_r.wdt_m;
		s_nxt.wdt_p = s_r.wdt_s;

		s_nxt.hosc_khz = hrc_khz(i_cfg.hrc_code);

		// read data is latched in the wait cycle, so it is stable
		// at the completing edge
		if (do_rd) begin
			s_nxt.rdata = 32'h0000_0000;
			case (i_address)
				OFS_OSC_CTRL: begin
					s_nxt.rdata[OSC_SEL_BIT]  = s_r.sys_clock_select;
					s_nxt.rdata[OSC_STOP_BIT] = s_r.high_osc_stop;
					s_nxt.rdata[OSC_MODE_LSB +: 2] =
						s_r.low_power_mode_field;
				end
				OFS_IRQ_FLAG: s_nxt.rdata[IRQ_W-1:0] = s_r.flag;
				OFS_IRQ_EN:   s_nxt.rdata[IRQ_W-1:0] = s_r.enable;
				OFS_PORT_CFG: begin
					s_nxt.rdata[PORT_W-1:0]   = s_r.port_wake_select;
					s_nxt.rdata[PCFG_EXT_SEL]  = s_r.ext_irq_select;
					s_nxt.rdata[PCFG_EDGE_SEL] = s_r.ext_edge_select;
				end
				OFS_STATUS: begin
					s_nxt.rdata[ST_GIE_BIT] = s_r.global_irq_enable;
					s_nxt.rdata[ST_PD_BIT]  = s_r.power_down_status_n;
					s_nxt.rdata[ST_TO_BIT]  = s_r.timeout_status_n;
					s_nxt.rdata[ST_MODE_LSB +: 5] = s_r.st;
				end
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// register writes; unmapped addresses are ignored
		if (wr_hit(i_address, OFS_OSC_CTRL, do_wr & i_byteenable[0]))
		begin
			s_nxt.sys_clock_select = i_writedata[OSC_SEL_BIT];
			s_nxt.high_osc_stop    = i_writedata[OSC_STOP_BIT];
			s_nxt.low_power_mode_field =
				i_writedata[OSC_MODE_LSB +: 2];
		end
		if (wr_hit(i_address, OFS_IRQ_EN, do_wr & i_byteenable[0]))
			s_nxt.enable = i_writedata[IRQ_W-1:0];
		if (wr_hit(i_address, OFS_PORT_CFG, do_wr & i_byteenable[0]))
			s_nxt.port_wake_select = i_writedata[PORT_W-1:0];
		if (wr_hit(i_address, OFS_PORT_CFG, do_wr & i_byteenable[1]))
		begin
			s_nxt.ext_irq_select  = i_writedata[PCFG_EXT_SEL];
			s_nxt.ext_edge_select = i_writedata[PCFG_EDGE_SEL];
		end

		// flags: written 0 clears, written 1 keeps; a new event
		// in the same cycle still wins
		if (wr_hit(i_address, OFS_IRQ_FLAG, do_wr & i_byteenable[0]))
			s_nxt.flag = s_r.flag & i_writedata[IRQ_W-1:0];
		s_nxt.flag = s_nxt.flag | ev_all;

		// watchdog timeout marks the timeout status
		if (s_r.wdt_s & ~s_r.wdt_p)
			s_nxt.timeout_status_n = 1'b0;

		// global enable from the core instructions
		if (i_irq_enable_instr)
			s_nxt.global_irq_enable = 1'b1;
		else if (i_irq_disable_instr)
			s_nxt.global_irq_enable = 1'b0;

		// instruction clock enable, only while executing
		if (s_r.st == ST_RUN) begin
			s_nxt.div_cnt = s_r.div_cnt + 2'd1;
			s_nxt.inst_pulse = i_cfg.inst_div4 ?
				(s_r.div_cnt == 2'd3) : s_r.div_cnt[0];
		end else begin
			s_nxt.div_cnt = 2'd0;
		end

		// operating mode sequencer
		case (s_r.st)
			ST_BOOT: begin
				// startup clock strap caught after reset release
				s_nxt.sys_clock_select = i_cfg.startup_high;
				s_nxt.st = ST_RUN;
			end
			ST_RUN: begin
				if (i_sleep_instr || (wr_hit(i_address,
				    OFS_OSC_CTRL, do_wr & i_byteenable[0]) &&
				    i_writedata[OSC_MODE_LSB +: 2] == MODE_HALT))
				begin
					s_nxt.st = ST_HALT;
					s_nxt.power_down_status_n = 1'b0;
					s_nxt.timeout_status_n    = 1'b1;
					s_nxt.wdt_clr             = 1'b1;
				end else if (wr_hit(i_address, OFS_OSC_CTRL,
				    do_wr & i_byteenable[0]) &&
				    i_writedata[OSC_MODE_LSB +: 2] == MODE_STANDBY)
				begin
					s_nxt.st = ST_STANDBY;
				end else if (s_r.global_irq_enable &&
				    |(s_r.flag & s_r.enable) &&
				    !i_irq_enable_instr) begin
					s_nxt.vec_pulse = 1'b1;
					s_nxt.global_irq_enable = 1'b0;
				end
			end
			ST_STANDBY: begin
				if (stby_wake) begin
					// no settle time, an oscillator kept running
					s_nxt.st = ST_RUN;
					s_nxt.low_power_mode_field = MODE_NONE;
					if (s_r.global_irq_enable) begin
						s_nxt.vec_pulse = 1'b1;
						s_nxt.global_irq_enable = 1'b0;
					end
				end
			end
			ST_HALT: begin
				if (halt_wake) begin
					s_nxt.st = ST_WAKE;
					s_nxt.wake_cnt = 5'd0;
				end
			end
			ST_WAKE: begin
				// oscillators restart; hold execution to settle
				if (s_r.wake_cnt == WAKE_LAST) begin
					s_nxt.st = ST_RUN;
					s_nxt.low_power_mode_field = MODE_NONE;
					if (s_r.global_irq_enable) begin
						s_nxt.vec_pulse = 1'b1;
						s_nxt.global_irq_enable = 1'b0;
					end
				end else begin
					s_nxt.wake_cnt = s_r.wake_cnt + 5'd1;
				end
			end
			default: s_nxt.st = ST_BOOT;
		endcase
	end

	// ----------------------------------------------------------
	// state register
	// ----------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_r                     <= '0;
			s_r.st                  <= ST_BOOT;
			s_r.sys_clock_select    <= 1'b1;
			s_r.power_down_status_n <= 1'b1;
			s_r.timeout_status_n    <= 1'b1;
			s_r.lvd_m               <= 1'b1;
			s_r.lvd_s               <= 1'b1;
			s_r.lvd_p               <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------
	// outputs
	// ----------------------------------------------------------
	logic halted;

	assign halted = (s_r.st == ST_HALT);

	// oscillator and gating; stop is honoured in any mode, firmware
	// is relied on to be in slow mode before setting it
	always_comb begin
		o_clk.high_osc_en = ~s_r.high_osc_stop & ~halted;
		o_clk.low_osc_en  = ~halted;
		o_clk.sys_clock_select = s_r.sys_clock_select;
		o_clk.exec_run    = (s_r.st == ST_RUN);
		o_clk.periph_run  = (s_r.st == ST_RUN);
		o_clk.timer_run   = (s_r.st == ST_RUN) |
		                    (s_r.st == ST_STANDBY);
		o_clk.high_osc_khz = s_r.hosc_khz;
		o_clk.low_osc_hz   = LOW_OSC_HZ_W;
	end

	assign o_readdata            = s_r.rdata;
	assign o_instruction_clock   = s_r.inst_pulse;
	assign o_irq_pending         = s_r.global_irq_enable &
	                               |(s_r.flag & s_r.enable);
	assign o_vector_take         = s_r.vec_pulse;
	assign o_vector_addr         = IRQ_VECTOR;
	assign o_wdt_clear           = s_r.wdt_clr;
	assign o_power_down_status_n = s_r.power_down_status_n;
	assign o_timeout_status_n    = s_r.timeout_status_n;

endmodule

// ===== tb/cmw_ctrl_asserts.sv
// port checker of the clock, mode and wake-up controller
// assumes it is bound onto cmw_ctrl, which has a single clock domain
`timescale 1ns/1ns

module cmw_ctrl_asserts
	import cmw_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire cmw_cfg_s    i_cfg,
	input wire logic        i_irq_enable_instr,
	input wire cmw_clk_s    o_clk,
	input wire logic        o_instruction_clock,
	input wire logic        o_irq_pending,
	input wire logic        o_vector_take,
	input wire logic [10:0] o_vector_addr,
	input wire logic        o_wdt_clear,
	input wire logic        o_power_down_status_n,
	input wire logic        o_timeout_status_n
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// ------------------------------
	// oscillators and operating mode
	// ------------------------------
	// only halt turns the low oscillator off, so it marks halt
	a_halt_all_off: assert property (
		!o_clk.low_osc_en |-> !(o_clk.high_osc_en || o_clk.exec_run
		|| o_clk.periph_run || o_clk.timer_run))
		else $error("halt leaves a clock or module running");
	a_low_osc_runs: assert property (
		o_clk.exec_run |-> o_clk.low_osc_en)
		else $error("low oscillator off while executing");
	a_low_osc_rate: assert property (
		o_clk.low_osc_hz == 16'h8000)
		else $error("low oscillator rate wrong");
	a_halt_entry: assert property (
		$fell(o_clk.low_osc_en) |-> !o_power_down_status_n
		&& o_timeout_status_n ##[0:1] o_wdt_clear)
		else $error("halt entry status or watchdog clear wrong");
	a_halt_wake: assert property (
		$rose(o_clk.low_osc_en) |-> !o_clk.exec_run [*8])
		else $error("execution resumed too early after halt");

	// ------------------------------
	// instruction clock and vectoring
	// ------------------------------
	a_inst_gap: assert property (
		o_instruction_clock |=> !o_instruction_clock)
		else $error("instruction clock faster than half rate");
	// guarded by a stable divider select, a change may shorten one gap
	a_inst_div4: assert property (
		o_instruction_clock && i_cfg.inst_div4 && $past(i_cfg.inst_div4, 4)
		|=> !o_instruction_clock [*3])
		else $error("instruction clock faster than quarter rate");
	a_irq_taken: assert property (
		o_irq_pending && o_clk.exec_run && !i_irq_enable_instr
		|-> ##[0:2] o_vector_take)
		else $error("pending interrupt not taken");
	a_vector_addr: assert property (
		o_vector_take |-> o_vector_addr == 11'h008)
		else $error("wrong vector address");
	a_take_clears: assert property (
		o_vector_take && !i_irq_enable_instr |=> !o_irq_pending)
		else $error("global enable not cleared on vector");

	c_vector: cover property (o_vector_take);
	c_halt: cover property ($fell(o_clk.low_osc_en));
	c_resume: cover property ($rose(o_clk.exec_run));
endmodule

// ===== tb/cmw_core_model.sv
// core model: avalon-mm master, firmware habits and instruction strobes
// assumes the controller answers on i_clk through waitrequest
`timescale 1ns/1ns

module cmw_core_model
	import cmw_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_waitrequest,
	input  wire logic [31:0] i_readdata,
	output logic      [4:0]  o_address,
	output logic             o_read,
	output logic             o_write,
	output logic      [31:0] o_writedata,
	output logic      [2:0]  o_instr
);
	logic [31:0] q;

	initial begin
		o_address = 5'h00;
		o_read = 1'b0;
		o_write = 1'b0;
		o_writedata = 32'h0000_0000;
		o_instr = 3'h0;
	end

	// ------------------------------
	// bus access, held until waitrequest is low
	// ------------------------------
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge i_clk);
		o_address <= a;
		o_writedata <= d;
		o_write <= w;
		o_read <= !w;
		// look at each rising edge before the slave's registers move
		do @(posedge i_clk); while (i_waitrequest !== 1'b0);
		r = i_readdata;
		o_read <= 1'b0;
		o_write <= 1'b0;
	endtask

	// one-cycle strobe: 0 sleep, 1 irq enable, 2 irq disable
	task automatic instr(input int k);
		@(posedge i_clk);
		o_instr[k] <= 1'b1;
		@(posedge i_clk);
		o_instr <= 3'h0;
	endtask

	// ------------------------------
	// firmware sequences
	// ------------------------------
	// slow first, stop later: both at once may hang the core
	task automatic slow_stop();
		acc(1'b1, OFS_OSC_CTRL, 32'h0000_0000, q);
		acc(1'b1, OFS_OSC_CTRL, 32'h0000_0002, q);
	endtask

	// standby entry also writes clock select 1, the high oscillator
	task automatic standby();
		acc(1'b1, OFS_OSC_CTRL, 32'h0000_0009, q);
	endtask

	task automatic clear_flags();
		acc(1'b1, OFS_IRQ_FLAG, 32'h0000_0000, q);
	endtask
endmodule

// ===== tb/testbench.sv
// self-checking bench of cmw_ctrl with the core model as bus master
// assumes a 25 MHz clock and events raised by the bench itself
`timescale 1ns/1ns

module testbench
	import cmw_pkg::*;
;
	logic        clk, rst, t0, t1, wdt, lvd;
	logic [5:0]  pins, pin_in;
	logic [4:0]  address;
	logic        read, write, waitreq, ic, irqp, vt, wclr, pdn, ton;
	logic [31:0] wdata, rdata, q;
	logic [2:0]  instr;
	logic [10:0] vaddr;
	cmw_cfg_s    cfg;
	cmw_clk_s    ock;
	int          fail_count, check_count, vt_n, ic_n, wl, v, n;

	cmw_core_model i_core (.i_clk(clk), .i_waitrequest(waitreq),
		.i_readdata(rdata), .o_address(address), .o_read(read),
		.o_write(write), .o_writedata(wdata), .o_instr(instr));
	cmw_ctrl i_dut (.i_clk(clk), .i_rst(rst), .i_address(address),
		.i_read(read), .i_write(write), .i_byteenable(4'hf),
		.i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
		.i_cfg(cfg), .i_sleep_instr(instr[0]), .i_irq_enable_instr(instr[1]),
		.i_irq_disable_instr(instr[2]), .i_timer0_ovf(t0), .i_timer1_udf(t1),
		.i_port_pins(pins), .i_port_is_input(pin_in), .i_low_volt_ok(lvd),
		.i_wdt_timeout(wdt), .o_clk(ock), .o_instruction_clock(ic),
		.o_irq_pending(irqp), .o_vector_take(vt), .o_vector_addr(vaddr),
		.o_wdt_clear(wclr), .o_power_down_status_n(pdn),
		.o_timeout_status_n(ton));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// pulse counters, and cycles spent stopped since the last halt
	always @(posedge clk) begin
		vt_n <= vt_n + int'(vt === 1'b1);
		ic_n <= ic_n + int'(ic === 1'b1);
		if (ock.low_osc_en !== 1'b1) wl <= 0;
		else if (ock.exec_run === 1'b0) wl <= wl + 1;
	end

	// ------------------------------
	// helpers
	// ------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		i_core.acc(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [4:0] a);
		i_core.acc(1'b0, a, 32'h0000_0000, q);
	endtask

	// raise one event source, then return it to rest
	task automatic ev(input int k);
		@(posedge clk);
		case (k)
			0: t0 <= 1'b1;
			1: t1 <= 1'b1;
			2: wdt <= 1'b1;
			3: pins[1] <= !pins[1];
			4: pins[0] <= 1'b1;
			default: lvd <= 1'b0;
		endcase
		@(posedge clk);
		t0 <= 1'b0;
		t1 <= 1'b0;
		repeat (6) @(posedge clk);
		wdt <= 1'b0;
		pins[0] <= 1'b0;
		lvd <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	task automatic summarize();
		if (fail_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#(40 * 10000);
		fail_count++;
		summarize();
	end

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		rst = 1'b1;
		{t0, t1, wdt, lvd, pins, pin_in} = {3'b000, 1'b1, 6'h00, 6'h3f};
		cfg = '{wdt_irq_mode: 1'b0, inst_div4: 1'b0, startup_high: 1'b1,
			hrc_code: 3'h5};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd(OFS_STATUS);
		chk(q[12:8], 5'h02);
		chk(ock.sys_clock_select, 1'b1);
		chk(ock.high_osc_khz, 16'h4e20);
		n = ic_n;
		repeat (40) @(posedge clk);
		chk(ic_n - n, 20);
		cfg.inst_div4 <= 1'b1;
		repeat (8) @(posedge clk);
		n = ic_n;
		repeat (40) @(posedge clk);
		chk(ic_n - n, 10);
		cfg.inst_div4 <= 1'b0;
		// watchdog in reset mode raises no flag
		ev(2);
		rd(OFS_IRQ_FLAG);
		chk(q, 0);
		cfg.wdt_irq_mode <= 1'b1;
		wr(OFS_IRQ_EN, 32'h0000_003f);
		wr(OFS_PORT_CFG, 32'h0000_033f);
		pin_in <= 6'h3d;
		ev(3);
		rd(OFS_IRQ_FLAG);
		chk(q, 0);
		pin_in <= 6'h3f;
		// each source sets its own flag only; pin0 is left to the edge
		for (int k = 0; k < 6; k++) begin
			ev(k);
			rd(OFS_IRQ_FLAG);
			chk(q, 32'h1 << k);
			chk(irqp, 1'b0);
			wr(OFS_IRQ_FLAG, ~(32'h1 << k));
			rd(OFS_IRQ_FLAG);
			chk(q, 0);
		end
		ev(5);
		v = vt_n;
		i_core.instr(1);
		repeat (4) @(posedge clk);
		chk(vt_n - v, 1);
		chk(irqp, 1'b0);
		i_core.clear_flags();
		wr(OFS_IRQ_EN, 32'h0000_0000);
		// standby leaves on every source; vector only with global enable
		for (int k = 0; k < 6; k++) begin
			i_core.instr(k % 2 == 1 ? 1 : 2);
			i_core.standby();
			rd(OFS_STATUS);
			chk(q[12:8], 5'h04);
			chk({ock.exec_run, ock.timer_run, ock.low_osc_en}, 3'b011);
			v = vt_n;
			ev(k);
			chk(ock.exec_run, 1'b1);
			rd(OFS_OSC_CTRL);
			chk(q[3:0], 4'h1);
			chk(vt_n - v, k % 2);
			i_core.clear_flags();
		end
		// halt leaves only on watchdog, port change or external edge
		for (int k = 0; k < 6; k++) begin
			if (k == 0) i_core.slow_stop();
			@(negedge clk);
			if (k == 0) chk(ock.high_osc_en, 1'b0);
			if (k % 2 == 1) i_core.instr(1);
			if (k % 2 == 1) wr(OFS_OSC_CTRL, 32'h0000_0005);
			else i_core.instr(0);
			@(negedge clk);
			chk({pdn, ton}, 2'b01);
			chk({ock.high_osc_en, ock.low_osc_en, ock.periph_run}, 0);
			v = vt_n;
			ev(k);
			if (k < 2 || k == 5) begin
				rd(OFS_STATUS);
				chk(q[12:8], 5'h08);
				ev(2);
			end
			repeat (24) @(posedge clk);
			chk(wl, 16);
			chk(vt_n - v, k % 2);
			if (k == 0) chk(ock.sys_clock_select, 1'b0);
			if (k == 0) wr(OFS_OSC_CTRL, 32'h0000_0001);
			i_core.clear_flags();
		end
		// second reset, starting from the low oscillator
		cfg.startup_high <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk(ock.sys_clock_select, 1'b0);
		summarize();
	end
endmodule

bind cmw_ctrl cmw_ctrl_asserts i_chk (.i_clk, .i_rst, .i_cfg,
	.i_irq_enable_instr, .o_clk, .o_instruction_clock, .o_irq_pending,
	.o_vector_take, .o_vector_addr, .o_wdt_clear, .o_power_down_status_n,
	.o_timeout_status_n);
